// File: pkg/osc_switch_pkg.sv
// constants shared by the oscillator switch control block
// assumes a 32-bit classic wishbone register port, byte addressed
package osc_switch_pkg;
	// register byte offsets
	localparam logic [7:0]  OSC_CTRL_OFFSET   = 8'h00;
	localparam logic [7:0]  UNLOCK_KEY_OFFSET = 8'h04;
	localparam logic [7:0]  OSC_STATUS_OFFSET = 8'h08;
	// oscillator_control field positions
	localparam int          SWITCH_REQ_BIT    = 0;
	localparam int          SEC_OSC_EN_BIT    = 1;
	localparam int          USB_FRC_SEL_BIT   = 2;
	localparam int          NEW_OSC_LSB       = 8;
	localparam int          NEW_OSC_W         = 3;
	// status field positions
	localparam int          STAT_UNLOCKED_BIT = 0;
	localparam int          STAT_PENDING_BIT  = 1;
	localparam int          STAT_CUR_OSC_LSB  = 4;
	// values after reset
	localparam logic [2:0]  CTRL_BITS_RESET   = 3'h0;
	localparam logic [2:0]  NEW_OSC_RESET     = 3'h0;
	localparam logic [2:0]  CUR_OSC_RESET     = 3'h0;
	// unlock keys, written in order to the key register
	localparam logic [31:0] UNLOCK_KEY_FIRST  = 32'h5A5A_1234;
	localparam logic [31:0] UNLOCK_KEY_SECOND = 32'hA5A5_4321;
	localparam logic [3:0]  SEL_ALL           = 4'hF;
	// stages of the ready-pin synchroniser
	localparam int          SYNC_STAGES       = 3;
endpackage

// File: hdl/unlock_seq.sv
// unlock sequence tracker for the protected control register
// assumes one write strobe per accepted bus write, same clock
`timescale 1ns/10ps
module unlock_seq (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	input  wire logic        wr_i,
	input  wire logic        key_wr_i,
	input  wire logic [31:0] key_data_i,
	input  wire logic        consume_i,
	output logic             unlocked_o
);
	typedef enum logic [1:0] {LOCKED, HALF, OPEN} unlock_state_t;
	unlock_state_t state_reg;
	unlock_state_t state_next;
	wire first_key  = key_wr_i && key_data_i == osc_switch_pkg::UNLOCK_KEY_FIRST;
	wire second_key = key_wr_i && key_data_i == osc_switch_pkg::UNLOCK_KEY_SECOND;

	// in HALF a first key holds, a second key opens, any other write relocks; consuming write relocks
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			LOCKED: if (first_key) state_next = HALF;
			HALF: if (wr_i) state_next = second_key ? OPEN : (first_key ? HALF : LOCKED);
			OPEN: if (consume_i) state_next = LOCKED;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			state_reg <= LOCKED;
		else if (ce_i)
			state_reg <= state_next;
	end

	assign unlocked_o = state_reg == OPEN;
endmodule

// File: hdl/oscillator_switch_control.sv
// oscillator control register with protected write path and switch sequencer
// assumes classic wishbone master on clk_i; osc_ready_i is asynchronous
`timescale 1ns/10ps
// How it works
// - usb_fast_rc_select high routes usb clock from internal fast rc, else primary/pll.
// - secondary oscillator runs exactly while its enable bit is one.
// - writing one to switch request starts a switch to new_osc_select, unless an earlier switch is still waiting for ready.
// - switch request reads one while pending, hardware clears it at completion.
// - control register writes are accepted only after the unlock key sequence.
module oscillator_switch_control (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	input  wire logic        osc_ready_i,
	output logic             usb_clk_fast_rc_o,
	output logic             sec_osc_enable_o,
	output logic             switch_busy_o,
	output logic      [2:0]  target_osc_o,
	output logic      [2:0]  sys_clk_src_o
);
	typedef enum logic {SW_IDLE, SW_WAIT} switch_state_t;

	logic          ack_reg;
	logic [31:0]   dat_reg;
	logic          usb_frc_reg;
	logic          sec_osc_reg;
	logic          switch_req_reg;
	logic [2:0]    new_osc_reg;
	logic [2:0]    target_reg;
	logic [2:0]    cur_osc_reg;
	logic [2:0]    ready_sync_reg;
	logic          ready_reg;
	switch_state_t sw_state_reg;
	switch_state_t sw_state_next;
	logic          unlocked;

	// field picked out of a write word once, used in two places
	function automatic logic [2:0] new_osc_field(input logic [31:0] word);
		return word[osc_switch_pkg::NEW_OSC_LSB +: osc_switch_pkg::NEW_OSC_W];
	endfunction

	// bus decode
	wire        bus_req   = cyc_i && stb_i;
	wire        wr_take   = bus_req && we_i && ack_reg;
	wire [5:0]  word_adr  = adr_i[7:2];
	wire        hit_ctrl  = word_adr == osc_switch_pkg::OSC_CTRL_OFFSET[7:2];
	wire        hit_key   = word_adr == osc_switch_pkg::UNLOCK_KEY_OFFSET[7:2];
	wire        hit_stat  = word_adr == osc_switch_pkg::OSC_STATUS_OFFSET[7:2];
	wire        key_wr    = wr_take && hit_key && sel_i == osc_switch_pkg::SEL_ALL;
	wire        ctrl_wr   = wr_take && hit_ctrl;
	wire        ctrl_ok   = ctrl_wr && unlocked;
	wire        low_wr    = ctrl_ok && sel_i[0];
	wire        high_wr   = ctrl_ok && sel_i[1];
	wire        start_req = low_wr && dat_i[osc_switch_pkg::SWITCH_REQ_BIT];
	wire        done      = sw_state_reg == SW_WAIT && ready_reg;
	wire        can_start = sw_state_reg == SW_IDLE || done;
	wire        start     = start_req && can_start;
	wire [2:0]  wr_new_osc = new_osc_field(dat_i);

	// ready counts once the last two stages agree
	wire        ready_next = (ready_sync_reg[1] == ready_sync_reg[2]) ? ready_sync_reg[2]
		: ready_reg;

	wire [31:0] ctrl_view = {16'h0000, 5'h00, new_osc_reg, 5'h00, usb_frc_reg,
		sec_osc_reg, switch_req_reg};
	wire [31:0] stat_view = {24'h000000, 1'b0, cur_osc_reg, 2'b00,
		switch_req_reg, unlocked};
	wire [31:0] rd_mux = hit_ctrl ? ctrl_view : (hit_stat ? stat_view : 32'h0000_0000);

	// any control write relocks, so a stray write cannot leave the gate open
	unlock_seq u_unlock (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.ce_i       (ce_i),
		.wr_i       (wr_take),
		.key_wr_i   (key_wr),
		.key_data_i (dat_i),
		.consume_i  (ctrl_wr),
		.unlocked_o (unlocked)
	);

	always_comb begin
		sw_state_next = sw_state_reg;
		unique case (sw_state_reg)
			SW_IDLE: if (start) sw_state_next = SW_WAIT;
			SW_WAIT: if (done && !start) sw_state_next = SW_IDLE;
		endcase
	end

	// single-cycle ack, dropped the cycle after it is given
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
		end else if (ce_i) begin
			ack_reg <= bus_req && !ack_reg;
			if (bus_req && !ack_reg)
				dat_reg <= rd_mux;
		end
	end

	// protected fields; a locked write falls through untouched
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			usb_frc_reg <= osc_switch_pkg::CTRL_BITS_RESET[osc_switch_pkg::USB_FRC_SEL_BIT];
			sec_osc_reg <= osc_switch_pkg::CTRL_BITS_RESET[osc_switch_pkg::SEC_OSC_EN_BIT];
			new_osc_reg <= osc_switch_pkg::NEW_OSC_RESET;
		end else if (ce_i) begin
			if (low_wr) begin
				usb_frc_reg <= dat_i[osc_switch_pkg::USB_FRC_SEL_BIT];
				sec_osc_reg <= dat_i[osc_switch_pkg::SEC_OSC_EN_BIT];
			end
			if (high_wr)
				new_osc_reg <= wr_new_osc;
		end
	end

	// new request in the completion cycle wins over the hardware clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			switch_req_reg <= osc_switch_pkg::CTRL_BITS_RESET[osc_switch_pkg::SWITCH_REQ_BIT];
			target_reg     <= osc_switch_pkg::CUR_OSC_RESET;
			cur_osc_reg    <= osc_switch_pkg::CUR_OSC_RESET;
			sw_state_reg   <= SW_IDLE;
		end else if (ce_i) begin
			sw_state_reg <= sw_state_next;
			if (done)
				cur_osc_reg <= target_reg;
			if (start) begin
				switch_req_reg <= 1'b1;
				target_reg     <= high_wr
					? wr_new_osc
					: new_osc_reg;
			end else if (done) begin
				switch_req_reg <= 1'b0;
			end
		end
	end

	// first stage may go metastable; only stages two and three are judged
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ready_sync_reg <= 3'h0;
			ready_reg      <= 1'b0;
		end else if (ce_i) begin
			ready_sync_reg <= {ready_sync_reg[1:0], osc_ready_i};
			ready_reg      <= ready_next;
		end
	end

	// outputs straight from flops, no decode glitches toward the clock tree
	assign ack_o             = ack_reg;
	assign dat_o             = dat_reg;
	assign usb_clk_fast_rc_o = usb_frc_reg;
	assign sec_osc_enable_o  = sec_osc_reg;
	assign switch_busy_o     = switch_req_reg;
	assign target_osc_o      = target_reg;
	assign sys_clk_src_o     = cur_osc_reg;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence locked_ctrl_write;
		ce_i && ctrl_wr && !unlocked;
	endsequence

	sequence bus_taken;
		ce_i && bus_req && !ack_reg;
	endsequence

	sequence unlock_opens;
		!unlocked ##1 unlocked;
	endsequence

	usb_source_a: assert property (ce_i && low_wr |=> usb_clk_fast_rc_o == $past(dat_i[2]))
		else $error("usb clock select did not follow the accepted write");
	sec_osc_a: assert property (ce_i && low_wr |=> sec_osc_enable_o == $past(dat_i[1]))
		else $error("secondary oscillator enable did not follow the accepted write");
	switch_start_a: assert property (ce_i && start |=> switch_busy_o && sw_state_reg == SW_WAIT)
		else $error("switch request did not start a switch");
	switch_clear_a: assert property (ce_i && done && !start |=> !switch_busy_o
		&& sys_clk_src_o == $past(target_reg))
		else $error("completed switch not cleared or source not updated");
	unlock_gate_a: assert property (ce_i && ctrl_wr |=> !unlocked)
		else $error("unlock survived a control register write");
	locked_write_a: assert property (locked_ctrl_write |=> $stable(usb_frc_reg)
		&& $stable(sec_osc_reg) && $stable(new_osc_reg)
		&& (switch_busy_o == $past(switch_busy_o) || $past(done)))
		else $error("locked write changed the control register");

	// bus answers in one cycle and never holds ack
	ack_answer_a: assert property (bus_taken |=> ack_o)
		else $error("bus request not answered one cycle later");
	ack_pulse_a: assert property (ce_i && ack_o |=> !ack_o)
		else $error("ack stood longer than one cycle");

	unlock_key_a: assert property (unlock_opens |->
		$past(key_wr) && $past(dat_i) == osc_switch_pkg::UNLOCK_KEY_SECOND)
		else $error("unlock opened without the second key");
	switch_hold_a: assert property (switch_busy_o && !done |=> switch_busy_o)
		else $error("pending switch request cleared before completion");
	switch_target_a: assert property (ce_i && start && high_wr |=>
		target_osc_o == $past(wr_new_osc))
		else $error("switch target not taken from the written field");
	locked_no_switch_a: assert property (ce_i && ctrl_wr && !unlocked
		&& !switch_busy_o |=> !switch_busy_o)
		else $error("locked write started a clock switch");
	usb_hold_a: assert property (ce_i && !low_wr |=> $stable(usb_clk_fast_rc_o)
		&& $stable(sec_osc_enable_o))
		else $error("usb select or secondary enable moved without an accepted write");
	ready_filter_a: assert property (ce_i && ready_sync_reg[1] != ready_sync_reg[2]
		|=> $stable(ready_reg))
		else $error("ready followed the synchroniser before its stages agreed");
	freeze_a: assert property (!ce_i |=> $stable(ack_o) && $stable(switch_busy_o)
		&& $stable(sys_clk_src_o) && $stable(target_osc_o))
		else $error("state moved while the clock enable was low");
endmodule

// File: verification/tb.sv
// self-checking bench for the oscillator switch control block
// assumes the block answers wishbone requests on clk_i; ready is driven by the bench
`timescale 1ns/10ps
module tb;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc_i = 1'b0;
	logic        stb_i = 1'b0;
	logic        we_i = 1'b0;
	logic [7:0]  adr_i = 8'h00;
	logic [3:0]  sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0;
	logic        osc_ready_i = 1'b0;
	logic        ce_i = 1'b1;
	logic [31:0] dat_o;
	logic        ack_o, usb_clk_fast_rc_o, sec_osc_enable_o, switch_busy_o;
	logic [2:0]  target_osc_o, sys_clk_src_o;
	logic [31:0] q;
	int          error_cnt = 0;
	int          num_checks = 0;

	always #10 clk_i = ~clk_i;

	oscillator_switch_control i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
		.ack_o(ack_o), .osc_ready_i(osc_ready_i), .usb_clk_fast_rc_o(usb_clk_fast_rc_o),
		.sec_osc_enable_o(sec_osc_enable_o), .switch_busy_o(switch_busy_o),
		.target_osc_o(target_osc_o), .sys_clk_src_o(sys_clk_src_o));

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// ack and read data are taken at the rising edge, before that edge updates them
	task automatic wb_wait();
		int n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		chk("bus ack", 32'h1, {31'h0, ack_o});
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i  <= 1'b0;
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s = 4'hF);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= s;
		wb_wait();
	endtask

	task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		chk(what, exp, q);
	endtask

	task automatic unlock();
		wb(1'b1, osc_switch_pkg::UNLOCK_KEY_OFFSET, osc_switch_pkg::UNLOCK_KEY_FIRST);
		wb(1'b1, osc_switch_pkg::UNLOCK_KEY_OFFSET, osc_switch_pkg::UNLOCK_KEY_SECOND);
	endtask

	task automatic wait_done();
		int n = 0;
		do begin
			@(negedge clk_i);
			n++;
		end while (switch_busy_o !== 1'b0 && n < 100);
		chk("switch busy", 32'h0, {31'h0, switch_busy_o});
	endtask

	task automatic test_locked();
		rd("ctrl reset", 8'h00, 32'h0);
		rd("unmapped", 8'h1C, 32'h0);
		rd("status reset", osc_switch_pkg::OSC_STATUS_OFFSET, 32'h0);
		wb(1'b1, osc_switch_pkg::UNLOCK_KEY_OFFSET, osc_switch_pkg::UNLOCK_KEY_FIRST);
		wb(1'b1, osc_switch_pkg::UNLOCK_KEY_OFFSET, osc_switch_pkg::UNLOCK_KEY_SECOND,
			4'h3);
		rd("status part key", osc_switch_pkg::OSC_STATUS_OFFSET, 32'h0);
		wb(1'b1, 8'h00, 32'h0000_0507);
		@(negedge clk_i);
		chk("busy locked", 32'h0, {31'h0, switch_busy_o});
		rd("ctrl locked", 8'h00, 32'h0);
		rd("key reads zero", osc_switch_pkg::UNLOCK_KEY_OFFSET, 32'h0);
		$display("test locked write done");
	endtask

	task automatic test_bits();
		unlock();
		rd("status open", osc_switch_pkg::OSC_STATUS_OFFSET, 32'h0000_0001);
		wb(1'b1, 8'h00, 32'h0000_0006);
		@(negedge clk_i);
		chk("usb fast rc", 32'h1, {31'h0, usb_clk_fast_rc_o});
		chk("sec osc en", 32'h1, {31'h0, sec_osc_enable_o});
		wb(1'b1, 8'h00, 32'h0000_0000);
		rd("ctrl relocked", 8'h00, 32'h0000_0006);
		unlock();
		wb(1'b1, 8'h00, 32'h0000_0002);
		@(negedge clk_i);
		chk("usb primary", 32'h0, {31'h0, usb_clk_fast_rc_o});
		chk("sec osc kept", 32'h1, {31'h0, sec_osc_enable_o});
		unlock();
		wb(1'b1, 8'h00, 32'h0000_0707, 4'h2);
		@(negedge clk_i);
		chk("busy lane off", 32'h0, {31'h0, switch_busy_o});
		rd("ctrl high lane", 8'h00, 32'h0000_0702);
		$display("test control bits done");
	endtask

	task automatic test_switch();
		unlock();
		wb(1'b1, 8'h00, 32'h0000_0301);
		@(negedge clk_i);
		chk("busy pending", 32'h1, {31'h0, switch_busy_o});
		chk("target", 32'h3, {29'h0, target_osc_o});
		chk("sec osc off", 32'h0, {31'h0, sec_osc_enable_o});
		rd("ctrl pending", 8'h00, 32'h0000_0301);
		rd("status pending", osc_switch_pkg::OSC_STATUS_OFFSET, 32'h0000_0002);
		@(posedge clk_i);
		osc_ready_i <= 1'b1;
		wait_done();
		chk("clock source", 32'h3, {29'h0, sys_clk_src_o});
		rd("ctrl done", 8'h00, 32'h0000_0300);
		rd("status done", osc_switch_pkg::OSC_STATUS_OFFSET, 32'h0000_0030);
		unlock();
		wb(1'b1, 8'h00, 32'h0000_0501);
		@(negedge clk_i);
		chk("busy second", 32'h1, {31'h0, switch_busy_o});
		wait_done();
		chk("second source", 32'h5, {29'h0, sys_clk_src_o});
		$display("test clock switch done");
	endtask

	// request raised while the enable is low must wait for it
	task automatic test_freeze();
		@(posedge clk_i);
		ce_i  <= 1'b0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= 1'b0;
		adr_i <= osc_switch_pkg::OSC_STATUS_OFFSET;
		sel_i <= 4'hF;
		repeat (3) begin
			@(posedge clk_i);
			chk("ack frozen", 32'h0, {31'h0, ack_o});
		end
		ce_i <= 1'b1;
		wb_wait();
		chk("status after freeze", 32'h0000_0050, q);
		$display("test clock enable done");
	endtask

	task automatic test_reset();
		unlock();
		wb(1'b1, 8'h00, 32'h0000_0006);
		unlock();
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		chk("usb after reset", 32'h0, {31'h0, usb_clk_fast_rc_o});
		chk("sec after reset", 32'h0, {31'h0, sec_osc_enable_o});
		chk("source after reset", 32'h0, {29'h0, sys_clk_src_o});
		chk("target after reset", 32'h0, {29'h0, target_osc_o});
		rd("status after reset", osc_switch_pkg::OSC_STATUS_OFFSET, 32'h0);
		$display("test mid-run reset done");
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		test_locked();
		test_bits();
		test_switch();
		test_freeze();
		test_reset();
		report_and_stop();
	end

	// the whole sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk_i);
		error_cnt++;
		report_and_stop();
	end
endmodule
